// ===== rtl/ptc_cfg.svh
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// register indices on the serial interface word select
`define PTC_IDX_REG_CTRL     4'h5
`define PTC_IDX_OSC_CTRL     4'h6

// data word carries bits 23..8 of each register
`define PTC_BASE             8
`define PTC_POS_CORE_TSD     (20 - `PTC_BASE)
`define PTC_POS_SECOND_TSD   (18 - `PTC_BASE)
`define PTC_POS_LINEAR_TSD   (17 - `PTC_BASE)
`define PTC_POS_LS_DRIVE     (11 - `PTC_BASE)
`define PTC_POS_HS_DRIVE     (8 - `PTC_BASE)
`define PTC_POS_RATE_SEL     (23 - `PTC_BASE)
`define PTC_POS_OUT_SRC      (19 - `PTC_BASE)
`define PTC_POS_OUT_PHASE    (16 - `PTC_BASE)
`define PTC_POS_OUT_FREQ     (15 - `PTC_BASE)
`define PTC_POS_EXT_SEL      (14 - `PTC_BASE)
`define PTC_POS_IN_DIV       (13 - `PTC_BASE)
`define PTC_POS_MOD_ON       (12 - `PTC_BASE)
`define PTC_POS_TUNE         (8 - `PTC_BASE)

// writable masks and reset values of each word
`define PTC_MASK_REG_CTRL    16'h161b
`define PTC_MASK_OSC_CTRL    16'hffbf
`define PTC_RST_REG_CTRL     16'h0000
`define PTC_RST_OSC_CTRL     16'h0000

// spread modulation and sync input divider
`define PTC_CLK_HZ           125000000
`define PTC_RATE_SLOW_HZ     23000
`define PTC_RATE_FAST_HZ     94000
`define PTC_SPREAD_PCT       5
`define PTC_MOD_STEPS        8
`define PTC_IN_DIV_RATIO     6

`endif

// ===== rtl/ptc_pkg.sv
package ptc_pkg;
  typedef enum logic [1:0] {
    PTC_DRV_SLOW  = 2'h0,
    PTC_DRV_MED   = 2'h1,
    PTC_DRV_FAST  = 2'h2,
    PTC_DRV_ULTRA = 2'h3
  } ptc_drive_t;

  typedef enum logic [2:0] {
    PTC_MOD_OFF  = 3'h1,
    PTC_MOD_UP   = 3'h2,
    PTC_MOD_DOWN = 3'h4
  } ptc_mod_state_t;
endpackage

// ===== rtl/ptc_phase_delay.sv
`timescale 1ns/1ps
module ptc_phase_delay #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // delay control
  input  wire logic       tick_20m,
  input  wire logic [2:0] phase,
  // signal
  input  wire logic       sig_in,
  output logic            sig_out
);
  logic [DEPTH-1:0] tap_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tap_ff <= '0;
    end else if (ce && tick_20m) begin
      tap_ff <= {tap_ff[DEPTH-2:0], sig_in};
    end
  end

  // tap chosen by the phase code, zero bypasses the line
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sig_out <= 1'b0;
    end else if (ce) begin
      sig_out <= (phase == 3'h0) ? sig_in : tap_ff[phase - 3'h1];
    end
  end
endmodule

// ===== rtl/ptc_regs.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_regs
  import ptc_pkg::*;
#(
  parameter logic [15:0] REG_CTRL_RESET = `PTC_RST_REG_CTRL
) (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // register access from the serial interface
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [3:0]  reg_idx,
  input  wire logic [15:0] wr_data,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  // thermal shutdown events
  input  wire logic        core_buck_thermal_shutdown,
  input  wire logic        second_buck_thermal_shutdown,
  input  wire logic        linear_reg_thermal_shutdown,
  // regulator actions
  output logic             core_buck_regulator_off,
  output logic             second_buck_regulator_off,
  output logic             linear_regulator_off,
  output logic             deep_fail_safe_state_req,
  // pre-regulator gate drive
  output ptc_drive_t       pre_reg_low_side_drive,
  output ptc_drive_t       pre_reg_high_side_drive,
  // oscillator and sync
  input  wire logic        tick_20m,
  input  wire logic        sync_input,
  input  wire logic        sync_out_source,
  output logic             sync_input_to_pll,
  output logic             sync_output,
  output logic             external_sync_select_request,
  output logic [3:0]       sync_out_source_select,
  output logic             sync_out_freq_select,
  output logic [3:0]       osc_tune,
  output logic             spread_modulation_on,
  output logic             spread_rate_select,
  output logic signed [4:0] spread_offset
);
  localparam int STEP_SLOW = `PTC_CLK_HZ / (`PTC_RATE_SLOW_HZ * 4 * `PTC_MOD_STEPS);
  localparam int STEP_FAST = `PTC_CLK_HZ / (`PTC_RATE_FAST_HZ * 4 * `PTC_MOD_STEPS);
  localparam logic signed [4:0] MOD_PEAK = 5'(`PTC_MOD_STEPS);
  localparam logic [1:0] DIV_LAST = 2'((`PTC_IN_DIV_RATIO / 2) - 1);

  logic [15:0]    reg_ctrl_ff;
  logic [15:0]    osc_ctrl_ff;
  logic [2:0]     tsd_prev_ff;
  logic [2:0]     tsd_now;
  logic [2:0]     tsd_fs_cfg;
  ptc_mod_state_t mod_state_ff;
  ptc_mod_state_t nxt_mod_state;
  logic [7:0]     step_cnt_ff;
  logic [7:0]     step_len;
  logic           step_tick;
  logic           sync_prev_ff;
  logic [1:0]     div_cnt_ff;
  logic           div_out_ff;
  logic           phase_out;

  function automatic logic hit(input logic en, input logic [3:0] idx, input logic [3:0] want);
    hit = en && (idx == want);
  endfunction

  // writes land only on writable bits, request bit never stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_ctrl_ff <= REG_CTRL_RESET & `PTC_MASK_REG_CTRL;
      osc_ctrl_ff <= `PTC_RST_OSC_CTRL;
    end else if (ce) begin
      if (hit(wr_en, reg_idx, `PTC_IDX_REG_CTRL)) begin
        reg_ctrl_ff <= wr_data & `PTC_MASK_REG_CTRL;
      end
      if (hit(wr_en, reg_idx, `PTC_IDX_OSC_CTRL)) begin
        osc_ctrl_ff <= wr_data & `PTC_MASK_OSC_CTRL;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (hit(rd_en, reg_idx, `PTC_IDX_REG_CTRL)) begin
        rd_data <= reg_ctrl_ff;
      end else if (hit(rd_en, reg_idx, `PTC_IDX_OSC_CTRL)) begin
        rd_data <= osc_ctrl_ff;
      end else begin
        rd_data <= 16'h0000;
      end
    end
  end

  // one-cycle request per write of 1, writing 0 does nothing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      external_sync_select_request <= 1'b0;
    end else if (ce) begin
      external_sync_select_request <= hit(wr_en, reg_idx, `PTC_IDX_OSC_CTRL)
                                      && wr_data[`PTC_POS_EXT_SEL];
    end
  end

  // thermal reactions
  assign tsd_now    = {core_buck_thermal_shutdown, second_buck_thermal_shutdown,
                       linear_reg_thermal_shutdown};
  assign tsd_fs_cfg = {reg_ctrl_ff[`PTC_POS_CORE_TSD], reg_ctrl_ff[`PTC_POS_SECOND_TSD],
                       reg_ctrl_ff[`PTC_POS_LINEAR_TSD]};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tsd_prev_ff               <= 3'h0;
      core_buck_regulator_off   <= 1'b0;
      second_buck_regulator_off <= 1'b0;
      linear_regulator_off      <= 1'b0;
      deep_fail_safe_state_req  <= 1'b0;
    end else if (ce) begin
      tsd_prev_ff               <= tsd_now;
      core_buck_regulator_off   <= tsd_now[2];
      second_buck_regulator_off <= tsd_now[1];
      linear_regulator_off      <= tsd_now[0];
      // pulse on the onset only, so a held fault asks once
      deep_fail_safe_state_req  <= |(tsd_now & ~tsd_prev_ff & tsd_fs_cfg);
    end
  end

  // gate drive and static oscillator fields
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_reg_low_side_drive  <= PTC_DRV_SLOW;
      pre_reg_high_side_drive <= PTC_DRV_SLOW;
      sync_out_source_select  <= 4'h0;
      sync_out_freq_select    <= 1'b0;
      osc_tune                <= 4'h0;
      spread_modulation_on    <= 1'b0;
      spread_rate_select      <= 1'b0;
    end else if (ce) begin
      pre_reg_low_side_drive  <= ptc_drive_t'(reg_ctrl_ff[`PTC_POS_LS_DRIVE +: 2]);
      pre_reg_high_side_drive <= ptc_drive_t'(reg_ctrl_ff[`PTC_POS_HS_DRIVE +: 2]);
      sync_out_source_select  <= osc_ctrl_ff[`PTC_POS_OUT_SRC +: 4];
      sync_out_freq_select    <= osc_ctrl_ff[`PTC_POS_OUT_FREQ];
      osc_tune                <= osc_ctrl_ff[`PTC_POS_TUNE +: 4];
      spread_modulation_on    <= osc_ctrl_ff[`PTC_POS_MOD_ON];
      spread_rate_select      <= osc_ctrl_ff[`PTC_POS_RATE_SEL];
    end
  end

  // triangle sweep, full code MOD_PEAK stands for the spread percentage
  assign step_len  = osc_ctrl_ff[`PTC_POS_RATE_SEL] ? 8'(STEP_FAST - 1) : 8'(STEP_SLOW - 1);
  // compare with >= so a rate change mid-step cannot stall the sweep
  assign step_tick = (step_cnt_ff >= step_len);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_cnt_ff <= 8'h00;
    end else if (ce) begin
      step_cnt_ff <= (step_tick || mod_state_ff == PTC_MOD_OFF) ? 8'h00 : step_cnt_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_mod_state = mod_state_ff;
    case (mod_state_ff)
      PTC_MOD_OFF: begin
        if (osc_ctrl_ff[`PTC_POS_MOD_ON]) nxt_mod_state = PTC_MOD_UP;
      end
      PTC_MOD_UP: begin
        if (!osc_ctrl_ff[`PTC_POS_MOD_ON]) nxt_mod_state = PTC_MOD_OFF;
        else if (step_tick && spread_offset == MOD_PEAK - 5'sd1) nxt_mod_state = PTC_MOD_DOWN;
      end
      PTC_MOD_DOWN: begin
        if (!osc_ctrl_ff[`PTC_POS_MOD_ON]) nxt_mod_state = PTC_MOD_OFF;
        else if (step_tick && spread_offset == -MOD_PEAK + 5'sd1) nxt_mod_state = PTC_MOD_UP;
      end
      default: nxt_mod_state = PTC_MOD_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_state_ff  <= PTC_MOD_OFF;
      spread_offset <= 5'sd0;
    end else if (ce) begin
      mod_state_ff <= nxt_mod_state;
      case (mod_state_ff)
        PTC_MOD_UP:   if (step_tick) spread_offset <= spread_offset + 5'sd1;
        PTC_MOD_DOWN: if (step_tick) spread_offset <= spread_offset - 5'sd1;
        default:      spread_offset <= 5'sd0;
      endcase
    end
  end

  // sync input divider: toggle every third rising edge gives divide by six
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_prev_ff      <= 1'b0;
      div_cnt_ff        <= 2'h0;
      div_out_ff        <= 1'b0;
      sync_input_to_pll <= 1'b0;
    end else if (ce) begin
      sync_prev_ff <= sync_input;
      if (sync_input && !sync_prev_ff) begin
        div_cnt_ff <= (div_cnt_ff == DIV_LAST) ? 2'h0 : div_cnt_ff + 2'h1;
        if (div_cnt_ff == DIV_LAST) div_out_ff <= ~div_out_ff;
      end
      sync_input_to_pll <= osc_ctrl_ff[`PTC_POS_IN_DIV] ? div_out_ff : sync_input;
    end
  end

  ptc_phase_delay #(
    .DEPTH (8)
  ) u_phase (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .tick_20m (tick_20m),
    .phase    (osc_ctrl_ff[`PTC_POS_OUT_PHASE +: 3]),
    .sig_in   (sync_out_source),
    .sig_out  (phase_out)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_output <= 1'b0;
    end else if (ce) begin
      sync_output <= phase_out;
    end
  end
endmodule

// ===== testbench/ptc_regs_asserts.sv
`timescale 1ns/1ps
module ptc_regs_asserts (
  // clock and reset
  input logic              clk_sys,
  input logic              rst,
  input logic              ce,
  // register access
  input logic              wr_en,
  input logic              rd_en,
  input logic [3:0]        reg_idx,
  input logic [15:0]       wr_data,
  input logic [15:0]       rd_data,
  input logic              rd_valid,
  // thermal
  input logic              core_buck_thermal_shutdown,
  input logic              second_buck_thermal_shutdown,
  input logic              linear_reg_thermal_shutdown,
  input logic              core_buck_regulator_off,
  input logic              second_buck_regulator_off,
  input logic              linear_regulator_off,
  input logic              deep_fail_safe_state_req,
  // oscillator
  input logic              external_sync_select_request,
  input logic              spread_modulation_on,
  input logic signed [4:0] spread_offset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic any_tsd;
  assign any_tsd = core_buck_thermal_shutdown | second_buck_thermal_shutdown
                   | linear_reg_thermal_shutdown;
  property p_rd_ack; ce && rd_en |=> rd_valid; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_unmapped; ce && rd_en && reg_idx != 4'h5 && reg_idx != 4'h6 |=> rd_data == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_req_bit; ce && rd_en && reg_idx == 4'h6 |=> !rd_data[6]; endproperty
  a_req_bit: assert property (p_req_bit) else $error("request bit reads back");
  property p_core; ce && core_buck_thermal_shutdown |=> core_buck_regulator_off; endproperty
  a_core: assert property (p_core) else $error("core buck not off");
  property p_second; ce && second_buck_thermal_shutdown |=> second_buck_regulator_off;
  endproperty
  a_second: assert property (p_second) else $error("second buck not off");
  property p_linear; ce && linear_reg_thermal_shutdown |=> linear_regulator_off; endproperty
  a_linear: assert property (p_linear) else $error("linear reg not off");
  property p_deep; deep_fail_safe_state_req |-> $past(any_tsd); endproperty
  a_deep: assert property (p_deep) else $error("fail-safe without fault");
  property p_ext; ce && wr_en && reg_idx == 4'h6 && wr_data[6] |=> external_sync_select_request;
  endproperty
  a_ext: assert property (p_ext) else $error("sync request missing");
  property p_mod_off; !spread_modulation_on [*2] |-> spread_offset == 0; endproperty
  a_mod_off: assert property (p_mod_off) else $error("offset while off");
  c_deep: cover property (deep_fail_safe_state_req);
  c_ext: cover property (external_sync_select_request);
  c_mod: cover property (spread_modulation_on && spread_offset != 0);
endmodule
bind ptc_regs ptc_regs_asserts u_chk (
  .clk_sys                      (clk_sys),
  .rst                          (rst),
  .ce                           (ce),
  .wr_en                        (wr_en),
  .rd_en                        (rd_en),
  .reg_idx                      (reg_idx),
  .wr_data                      (wr_data),
  .rd_data                      (rd_data),
  .rd_valid                     (rd_valid),
  .core_buck_thermal_shutdown   (core_buck_thermal_shutdown),
  .second_buck_thermal_shutdown (second_buck_thermal_shutdown),
  .linear_reg_thermal_shutdown  (linear_reg_thermal_shutdown),
  .core_buck_regulator_off      (core_buck_regulator_off),
  .second_buck_regulator_off    (second_buck_regulator_off),
  .linear_regulator_off         (linear_regulator_off),
  .deep_fail_safe_state_req     (deep_fail_safe_state_req),
  .external_sync_select_request (external_sync_select_request),
  .spread_modulation_on         (spread_modulation_on),
  .spread_offset                (spread_offset)
);

// ===== testbench/ptc_regs_tb.sv
`timescale 1ns/1ps
module ptc_regs_tb;
  import ptc_pkg::*;
  logic              clk_sys = 0, rst = 1, ce = 1, wr_en = 0, rd_en = 0;
  logic [3:0]        reg_idx = 0, sync_out_source_select, osc_tune;
  logic [15:0]       wr_data = 0, rd_data;
  logic              rd_valid, tick_20m = 0, sync_input = 0, sync_out_source = 0;
  logic [2:0]        thermal_shutdown = 0;
  logic              core_buck_regulator_off, second_buck_regulator_off;
  logic              linear_regulator_off, deep_fail_safe_state_req, ext_seen;
  logic              sync_input_to_pll, sync_output, external_sync_select_request;
  logic              sync_out_freq_select, spread_modulation_on, spread_rate_select;
  logic signed [4:0] spread_offset;
  ptc_drive_t        pre_reg_low_side_drive, pre_reg_high_side_drive;
  int                fails = 0, checks = 0, n, d, k;
  wire               core_buck_thermal_shutdown = thermal_shutdown[0];
  wire               second_buck_thermal_shutdown = thermal_shutdown[1];
  wire               linear_reg_thermal_shutdown = thermal_shutdown[2];
  ptc_regs u_dut (
    .clk_sys                      (clk_sys),
    .rst                          (rst),
    .ce                           (ce),
    .wr_en                        (wr_en),
    .rd_en                        (rd_en),
    .reg_idx                      (reg_idx),
    .wr_data                      (wr_data),
    .rd_data                      (rd_data),
    .rd_valid                     (rd_valid),
    .core_buck_thermal_shutdown   (core_buck_thermal_shutdown),
    .second_buck_thermal_shutdown (second_buck_thermal_shutdown),
    .linear_reg_thermal_shutdown  (linear_reg_thermal_shutdown),
    .core_buck_regulator_off      (core_buck_regulator_off),
    .second_buck_regulator_off    (second_buck_regulator_off),
    .linear_regulator_off         (linear_regulator_off),
    .deep_fail_safe_state_req     (deep_fail_safe_state_req),
    .pre_reg_low_side_drive       (pre_reg_low_side_drive),
    .pre_reg_high_side_drive      (pre_reg_high_side_drive),
    .tick_20m                     (tick_20m),
    .sync_input                   (sync_input),
    .sync_out_source              (sync_out_source),
    .sync_input_to_pll            (sync_input_to_pll),
    .sync_output                  (sync_output),
    .external_sync_select_request (external_sync_select_request),
    .sync_out_source_select       (sync_out_source_select),
    .sync_out_freq_select         (sync_out_freq_select),
    .osc_tune                     (osc_tune),
    .spread_modulation_on         (spread_modulation_on),
    .spread_rate_select           (spread_rate_select),
    .spread_offset                (spread_offset)
  );
  always #4 clk_sys = ~clk_sys;
  task automatic cyc(input int c = 1);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [15:0] dat);
    wr_en = 1;
    reg_idx = idx;
    wr_data = dat;
    cyc();
    ext_seen = external_sync_select_request;
    wr_en = 0;
    cyc(2);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    rd_en = 1;
    reg_idx = idx;
    cyc();
    rd_en = 0;
    chk(rd_data, exp);
    chk(16'(rd_valid), 16'h0001);
    cyc();
  endtask
  // delay from source edge to shifted output
  task automatic meas(output int dl);
    sync_out_source = 1;
    dl = 0;
    while (sync_output !== 1'b1 && dl < 100) begin
      cyc();
      dl++;
    end
    sync_out_source = 0;
    cyc(100);
  endtask
  // first wait only aligns to a step edge
  task automatic step(output int c);
    logic signed [4:0] v;
    repeat (2) begin
      v = spread_offset;
      c = 0;
      while (spread_offset === v && c < 400) begin
        cyc();
        c++;
      end
    end
  endtask
  task automatic divc(output int c);
    logic p;
    c = 0;
    p = sync_input_to_pll;
    repeat (24) begin
      sync_input = ~sync_input;
      cyc(2);
      if (sync_input_to_pll === 1'b1 && p !== 1'b1) c++;
      p = sync_input_to_pll;
    end
  endtask
  initial forever begin
    cyc(5);
    tick_20m = 1;
    cyc();
    tick_20m = 0;
  end
  initial begin
    cyc(20000);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    cyc(8);
    rst = 0;
    cyc();
    rd(4'h5, 16'h0000);
    rd(4'h6, 16'h0000);
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h161b);
    for (k = 0; k < 4; k++) begin
      wr(4'h5, 16'((k << 3) | k));
      chk(16'(pre_reg_low_side_drive), 16'(k));
      chk(16'(pre_reg_high_side_drive), 16'(k));
    end
    wr(4'h6, 16'hffff);
    chk(16'(ext_seen), 16'h0001);
    rd(4'h6, 16'hffbf);
    chk(16'(sync_out_source_select), 16'h000f);
    chk(16'(sync_out_freq_select), 16'h0001);
    chk(16'(osc_tune), 16'h000f);
    chk(16'(spread_rate_select), 16'h0001);
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h0000);
    // enable low must freeze the register file
    ce = 0;
    wr(4'h5, 16'h0000);
    ce = 1;
    rd(4'h5, 16'h001b);
    wr(4'h5, 16'h1600);
    for (k = 0; k < 6; k++) begin
      thermal_shutdown = 3'(1 << (k % 3));
      cyc();
      chk(16'({linear_regulator_off, second_buck_regulator_off, core_buck_regulator_off}),
          16'(thermal_shutdown));
      chk(16'(deep_fail_safe_state_req), 16'(k < 3));
      thermal_shutdown = 0;
      cyc(2);
      if (k == 2) wr(4'h5, 16'h0000);
    end
    wr(4'h6, 16'h0020);
    chk(16'(ext_seen), 16'h0000);
    divc(n);
    chk(16'(n), 16'h0002);
    wr(4'h6, 16'h0000);
    divc(n);
    chk(16'(n), 16'h000c);
    meas(d);
    chk(16'(d), 16'h0002);
    wr(4'h6, 16'h0700);
    meas(d);
    chk(16'(d >= 38 && d <= 50), 16'h0001);
    wr(4'h6, 16'h0010);
    chk(16'(spread_modulation_on), 16'h0001);
    step(n);
    chk(16'(n), 16'h00a9);
    wr(4'h6, 16'h8010);
    step(n);
    chk(16'(n), 16'h0029);
    wr(4'h6, 16'h0000);
    cyc(4);
    chk(16'(spread_offset), 16'h0000);
    print_verdict();
  end
endmodule
